// ==== logic/tcp_map.svh ====
// Purpose: Offsets, field positions, reset values and codes of the timing coprocessor
// Assumes: 32-bit APB, one aligned word per register
// Notes: Definitions only
`ifndef TCP_MAP_SVH
`define TCP_MAP_SVH
`define TCP_AW 12
`define TCP_OFF_CFG 12'h000
`define TCP_OFF_FUNC 12'h004
`define TCP_OFF_PRIO 12'h008
`define TCP_OFF_HSR 12'h00C
`define TCP_OFF_TBSEL 12'h010
`define TCP_OFF_STAT 12'h014
`define TCP_RAM_PAGE 4'h1
`define TCP_CFG_RST 8'h00
`define TCP_FUNC_RST 32'h00000000
`define TCP_PRIO_RST 32'h00000000
`define TCP_TBSEL_RST 32'h00000000
`define TCP_LAST_RST 4'hF
`define TCP_ROM_F0 5'h00
`define TCP_ROM_F1 5'h0B
`define TCP_ROM_F2 5'h14
`define TCP_ROM_F3 5'h19
`define TCP_PRIO_OFF 2'h0
`define TCP_PRIO_LOW 2'h1
`define TCP_PRIO_MID 2'h2
`define TCP_PRIO_HIGH 2'h3
`define TCP_PW_OFFSET 3'h1
`define TCP_PW_CAPT 3'h2
`define TCP_PW_TIME 3'h3
`endif

// ==== logic/tcp_pkg.sv ====
// Purpose: Types shared by the timing coprocessor core
// Assumes: Constants live in tcp_map.svh
// Notes: Engine states are Gray coded along idle-fetch-exec-done
package tcp_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_FETCH = 2'h1,
    ST_EXEC = 2'h3,
    ST_DONE = 2'h2
  } tcp_eng_st_t;
  // One microcode word: what the engine does for the granted channel
  typedef struct packed {
    logic link;
    logic rearm;
    logic capture;
    logic toggle;
    logic drive;
  } tcp_instr_t;
  typedef struct packed {
    logic [15:0] level;
    logic [15:0] oe_n;
  } tcp_pins_t;
  typedef struct packed {
    logic emu;
    logic tb2_ext;
    logic [2:0] tb2_exp;
    logic [2:0] tb1_exp;
  } tcp_cfg_t;
endpackage : tcp_pkg

// ==== logic/tcp_core.sv ====
// Purpose: Timing coprocessor core: time bases, 16 channels, scheduler, engine, parameter RAM
// Assumes: Single clock pclk at 25 MHz; APB slave with zero wait states
// Notes: Channel and external clock pins are synchronised by two flops
//
// Contract
// - Two 16-bit time bases, each prescaled by host-written configuration fields.
// - Engine reads both time bases; host has no direct read path to them.
// - First base divides system clock; second may count external timebase pin edges.
// - Sixteen identical channels, each with own pin, event register and pin control.
// - Each channel has capture, match registers and greater-or-equal comparator.
// - Pin direction is set only by the engine, never by host registers.
// - Match and capture may use the same or different time bases.
// - Service requests come from host, link, match or capture causes.
// - Host gives three priority levels; grant uses level, then rotation in channel order from the last served.
// - Granted channel runs its assigned function from internal ROM or emulation RAM.
// - Parameter RAM is 256 bytes at top of map, 128 words, all reachable.
// - Channels 0-13 own six words, 14 and 15 own eight.
// - Host writes parameters; engine reads them and writes results back.
// - Per-channel independent match and capture hardware, one time-base clock accuracy.
// - Events post requests; scheduler hands channel to engine at first free slot.
// - Host registers reachable over the bus before and during function execution.
// - Same-level pending requests rotate in channel order after each service.
// - A 32-bit access moves two adjacent parameter words coherently.
`timescale 1ns/1ps
`include "tcp_map.svh"
module tcp_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`TCP_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] chan_pin_in,
  output tcp_pkg::tcp_pins_t chan_pins,
  input wire logic external_timebase_clock_pin,
  output logic [8:0] emu_addr,
  input wire logic [31:0] emu_data
);
  import tcp_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Decoding used by several processes
  function automatic logic [4:0] rr_pick(input logic [15:0] m, input logic [3:0] last);
    logic [4:0] r;
    logic [3:0] k;
    r = 5'h00;
    for (int i = 1; i <= 16; i++) begin
      k = 4'(last + 4'(i));
      if (m[k] && !r[4]) begin
        r = {1'b1, k};
      end
    end
    return r;
  endfunction : rr_pick

  function automatic logic tick_of(input logic [7:0] cnt, input logic [2:0] e);
    logic [7:0] m;
    m = 8'((9'h001 << e) - 9'h001);
    return (cnt & m) == m;
  endfunction : tick_of

  function automatic logic [4:0] rom_word(input logic [1:0] f);
    logic [4:0] w;
    unique case (f)
      2'h0: w = `TCP_ROM_F0;
      2'h1: w = `TCP_ROM_F1;
      2'h2: w = `TCP_ROM_F2;
      2'h3: w = `TCP_ROM_F3;
    endcase
    return w;
  endfunction : rom_word

  //////////////////////////////////////////////////////////////////////////////
  tcp_cfg_t cfg_q;
  logic [31:0] func_q, prio_q, tbsel_q;
  logic [15:0] pend_q, dir_q, level_q;
  logic [15:0] pin_s1_q, pin_s2_q, pin_s3_q;
  logic [2:0] ext_s_q;
  logic [7:0] pre1_q, pre2_q;
  logic [15:0] tb1_q, tb2_q;
  logic [15:0] ram_q [128];
  logic [15:0] cap_q [16];
  logic [15:0] match_q [16];
  logic [15:0] armed_q, match_hit, edge_ev, hsr_set, link_set;
  logic [3:0] last_q [4];
  logic [3:0] cur_ch_q;
  tcp_eng_st_t st_q;
  tcp_instr_t instr_q;
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;
  tcp_pins_t pins_q;
  logic [8:0] emu_addr_q;
  logic tb1_tick, tb2_src, tb2_tick;
  logic apb_setup, apb_wr, setup_ram;
  logic [6:0] ram_idx;
  logic exec;
  logic [4:0] pick_h, pick_m, pick_l;
  logic grant;
  logic [3:0] grant_ch;
  logic [1:0] grant_lvl;

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign chan_pins = pins_q;
  assign emu_addr = emu_addr_q;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; third stage only feeds edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q <= 16'h0000;
      pin_s2_q <= 16'h0000;
      pin_s3_q <= 16'h0000;
      ext_s_q <= 3'h0;
    end else begin
      pin_s1_q <= chan_pin_in;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      ext_s_q <= {ext_s_q[1:0], external_timebase_clock_pin};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Time bases; external source counts rising edges, so it must run below pclk/2
  assign tb1_tick = tick_of(pre1_q, cfg_q.tb1_exp);
  assign tb2_src = cfg_q.tb2_ext ? (ext_s_q[1] & ~ext_s_q[2]) : 1'b1;
  assign tb2_tick = tb2_src & tick_of(pre2_q, cfg_q.tb2_exp);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre1_q <= 8'h00;
      pre2_q <= 8'h00;
      tb1_q <= 16'h0000;
      tb2_q <= 16'h0000;
    end else begin
      pre1_q <= pre1_q + 8'h01;
      if (tb2_src) begin
        pre2_q <= pre2_q + 8'h01;
      end
      if (tb1_tick) begin
        tb1_q <= tb1_q + 16'h0001;
      end
      if (tb2_tick) begin
        tb2_q <= tb2_q + 16'h0001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB slave: read data is latched in setup, so access phase always has pready
  assign apb_setup = psel & ~penable;
  assign apb_wr = psel & penable & pwrite & pready_q;
  assign setup_ram = paddr[11:8] == `TCP_RAM_PAGE;
  assign ram_idx = {paddr[7:2], 1'b0};
  assign hsr_set = (apb_wr && paddr == `TCP_OFF_HSR) ? pwdata[15:0] : 16'h0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else if (apb_setup) begin
      pready_q <= 1'b1;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
      if (setup_ram) begin
        prdata_q <= {ram_q[ram_idx + 7'h01], ram_q[ram_idx]};
      end else begin
        unique case (paddr)
          `TCP_OFF_CFG: prdata_q <= {24'h000000, cfg_q};
          `TCP_OFF_FUNC: prdata_q <= func_q;
          `TCP_OFF_PRIO: prdata_q <= prio_q;
          `TCP_OFF_HSR: prdata_q <= {16'h0000, pend_q};
          `TCP_OFF_TBSEL: prdata_q <= tbsel_q;
          `TCP_OFF_STAT: prdata_q <= {11'h000, st_q != ST_IDLE, cur_ch_q, dir_q};
          default: pslverr_q <= 1'b1;
        endcase
      end
    end else begin
      pready_q <= 1'b1;
    end
  end

  // Host configuration; no host path touches pin direction or the time bases
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= `TCP_CFG_RST;
      func_q <= `TCP_FUNC_RST;
      prio_q <= `TCP_PRIO_RST;
      tbsel_q <= `TCP_TBSEL_RST;
    end else if (apb_wr) begin
      unique case (paddr)
        `TCP_OFF_CFG: cfg_q <= pwdata[7:0];
        `TCP_OFF_FUNC: func_q <= pwdata;
        `TCP_OFF_PRIO: prio_q <= pwdata;
        `TCP_OFF_TBSEL: tbsel_q <= pwdata;
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Parameter RAM: 128 words, channel c owns words c*8 onward (6 used below 14)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 128; i++) begin
        ram_q[i] <= 16'h0000;
      end
    end else begin
      if (exec && instr_q.capture) begin
        ram_q[{cur_ch_q, `TCP_PW_CAPT}] <= cap_q[cur_ch_q];
        ram_q[{cur_ch_q, `TCP_PW_TIME}] <= tb1_q;
      end
      // Host write lands after the engine one, so the host wins a collision
      if (apb_wr && setup_ram) begin
        ram_q[ram_idx] <= pwdata[15:0];
        ram_q[ram_idx + 7'h01] <= pwdata[31:16];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Channels
  assign exec = st_q == ST_EXEC;
  assign link_set = (exec && instr_q.link) ? 16'(16'h0001 << (cur_ch_q + 4'h1)) : 16'h0000;
  assign edge_ev = (pin_s2_q ^ pin_s3_q) & ~dir_q;

  for (genvar c = 0; c < 16; c++) begin : g_ch
    logic [15:0] tb_m, tb_c;
    logic here;
    assign tb_m = tbsel_q[c] ? tb2_q : tb1_q;
    assign tb_c = tbsel_q[16 + c] ? tb2_q : tb1_q;
    assign here = exec && cur_ch_q == 4'(c);
    assign match_hit[c] = armed_q[c] && tb_m >= match_q[c];

    // Event register; each channel compares on its own every cycle
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cap_q[c] <= 16'h0000;
        match_q[c] <= 16'h0000;
        armed_q[c] <= 1'b0;
      end else begin
        if (edge_ev[c]) begin
          cap_q[c] <= tb_c;
        end
        if (here && instr_q.rearm) begin
          match_q[c] <= tb_m + ram_q[7'(c * 8) + 7'(`TCP_PW_OFFSET)];
          armed_q[c] <= 1'b1;
        end else if (match_hit[c]) begin
          armed_q[c] <= 1'b0;
        end
      end
    end

    // Request flag: a new cause in the grant cycle keeps the flag set
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pend_q[c] <= 1'b0;
      end else if (hsr_set[c] | link_set[c] | match_hit[c] | edge_ev[c]) begin
        pend_q[c] <= 1'b1;
      end else if (grant && grant_ch == 4'(c)) begin
        pend_q[c] <= 1'b0;
      end
    end

    // Pin control, owned by the engine only
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        dir_q[c] <= 1'b0;
        level_q[c] <= 1'b0;
      end else if (here) begin
        dir_q[c] <= instr_q.drive;
        level_q[c] <= level_q[c] ^ instr_q.toggle;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_q <= {16'h0000, 16'hFFFF};
    end else begin
      pins_q <= {level_q, ~dir_q};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Scheduler: strict level order, rotation within a level
  always_comb begin
    logic [15:0] mh, mm, ml;
    mh = 16'h0000;
    mm = 16'h0000;
    ml = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      mh[i] = pend_q[i] && prio_q[2*i +: 2] == `TCP_PRIO_HIGH;
      mm[i] = pend_q[i] && prio_q[2*i +: 2] == `TCP_PRIO_MID;
      ml[i] = pend_q[i] && prio_q[2*i +: 2] == `TCP_PRIO_LOW;
    end
    pick_h = rr_pick(mh, last_q[3]);
    pick_m = rr_pick(mm, last_q[2]);
    pick_l = rr_pick(ml, last_q[1]);
  end

  always_comb begin
    grant_lvl = `TCP_PRIO_OFF;
    grant_ch = 4'h0;
    if (pick_h[4]) begin
      grant_lvl = `TCP_PRIO_HIGH;
      grant_ch = pick_h[3:0];
    end else if (pick_m[4]) begin
      grant_lvl = `TCP_PRIO_MID;
      grant_ch = pick_m[3:0];
    end else if (pick_l[4]) begin
      grant_lvl = `TCP_PRIO_LOW;
      grant_ch = pick_l[3:0];
    end
  end
  assign grant = st_q == ST_IDLE && grant_lvl != `TCP_PRIO_OFF;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int l = 0; l < 4; l++) begin
        last_q[l] <= `TCP_LAST_RST;
      end
    end else if (grant) begin
      last_q[grant_lvl] <= grant_ch;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Engine: fixed four-cycle service, so host access is never blocked by it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_IDLE;
      cur_ch_q <= 4'h0;
      instr_q <= 5'h00;
      emu_addr_q <= 9'h000;
    end else begin
      unique case (st_q)
        ST_IDLE: if (grant) begin
          st_q <= ST_FETCH;
          cur_ch_q <= grant_ch;
          emu_addr_q <= {3'h0, func_q[2*grant_ch +: 2], grant_ch};
        end
        ST_FETCH: begin
          st_q <= ST_EXEC;
          instr_q <= cfg_q.emu ? emu_data[4:0] : rom_word(func_q[2*cur_ch_q +: 2]);
        end
        ST_EXEC: st_q <= ST_DONE;
        ST_DONE: st_q <= ST_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_tb1_counts: assert property (tb1_tick |=> tb1_q == $past(tb1_q) + 16'h0001)
    else $error("time base one missed a tick");
  a_tb2_ext_hold: assert property (cfg_q.tb2_ext && !(ext_s_q[1] && !ext_s_q[2])
    |=> $stable(tb2_q))
    else $error("time base two moved without an external edge");
  a_cap_latch: assert property (edge_ev[1] && !tbsel_q[17]
    |=> cap_q[1] == $past(tb1_q))
    else $error("capture did not hold the time base");
  a_match_req: assert property (match_hit[0] && !(exec && cur_ch_q == 4'h0)
    |=> pend_q[0] && !armed_q[0])
    else $error("match event lost");
  a_hsr_sets: assert property (hsr_set[5] |=> pend_q[5])
    else $error("host request not posted");
  a_grant_level: assert property (grant && pick_h[4] |-> prio_q[2*grant_ch +: 2] == 2'h3)
    else $error("lower level granted over high level");
  a_engine_seq: assert property (st_q == ST_IDLE && grant
    |=> st_q == ST_FETCH ##1 st_q == ST_EXEC ##1 st_q == ST_DONE ##1 st_q == ST_IDLE)
    else $error("engine sequence broken");
  a_off_not_served: assert property (grant |-> prio_q[2*grant_ch +: 2] != 2'h0)
    else $error("disabled channel granted");
  a_rr_moves: assert property (grant && grant_lvl == 2'h1 |=> last_q[1] == $past(grant_ch))
    else $error("rotation pointer not updated");
  a_ram_pair: assert property (apb_wr && setup_ram
    |=> {ram_q[$past(ram_idx) + 7'h01], ram_q[$past(ram_idx)]} == $past(pwdata))
    else $error("parameter pair not written together");
  a_apb_ready: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
endmodule : tcp_core

// ==== verif/tcp_host_model.sv ====
// Purpose: Host processor model that issues APB transfers into the core
// Assumes: pready is sampled at rising edges; any number of wait states
// Notes: Released address and data lines show the inverse of the last value
`timescale 1ns/1ps
module tcp_host_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  ////////////////////////////////////////////////////////////////////////////
  // Bus idle at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // One transfer; request held until pready is seen high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench watchdog ends a wait that never sees ready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata; // One word carries both parameter halves
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a; // Stale values would hide decode faults
    pwdata <= ~d;
  endtask : xfer
endmodule : tcp_host_model

// ==== verif/tb.sv ====
// Purpose: Self-checking bench for the timing coprocessor core
// Assumes: Zero-wait APB slave, four cycles per engine service
// Notes: Grant order is read from emu_addr changes
`timescale 1ns/1ps
`include "tcp_map.svh"
module tb;
  import tcp_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [31:0] emu_data = 32'h0;
  logic [15:0] pin_in = 16'h0;
  logic ext_pin = 1'b0;
  logic ext_ph = 1'b0;
  logic ext_run = 1'b0;
  logic [8:0] emu_addr;
  logic [8:0] last_ea = 9'h0;
  tcp_pins_t chan_pins;
  logic [3:0] order_q[$];
  logic [3:0] exp_ord[6] = '{4'h4, 4'h5, 4'h3, 4'h4, 4'h5, 4'h4};
  logic [11:0] offs[5] = '{`TCP_OFF_CFG, `TCP_OFF_FUNC, `TCP_OFF_PRIO, `TCP_OFF_HSR,
                           `TCP_OFF_TBSEL};
  int ram_k[3] = '{0, 28, 63};
  int err_total = 0;
  int comparisons = 0;
  int n;
  always #20 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////////
  tcp_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chan_pin_in(pin_in), .chan_pins(chan_pins),
    .external_timebase_clock_pin(ext_pin), .emu_addr(emu_addr), .emu_data(emu_data));
  tcp_host_model u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  ////////////////////////////////////////////////////////////////////////////
  // A grant shows as a change of emu_addr only if its channel or function differs from the grant before
  always @(posedge pclk) begin
    last_ea <= emu_addr;
    if (emu_addr !== last_ea) order_q.push_back(emu_addr[3:0]);
  end
  // Second time-base source: one rising edge every four cycles while running
  always @(posedge pclk) begin
    if (ext_run) {ext_pin, ext_ph} <= {ext_pin, ext_ph} + 2'h1;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic rng(input string nm, input int v, input int lo, input int hi);
    chk(nm, (v >= lo && v <= hi) ? 32'h1 : 32'h0, 32'h1);
  endtask : rng
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    u_host.xfer(1'b0, a, 32'h0, q, e);
  endtask : rd
  task automatic w(input int c);
    repeat (c) @(negedge pclk);
  endtask : w
  // Cycles until a channel level changes; -1 when it holds for lim cycles
  task automatic meas(input int ch, input int lim);
    logic v;
    v = chan_pins.level[ch];
    n = -1;
    for (int i = 1; i <= lim; i++) begin
      @(negedge pclk);
      if (chan_pins.level[ch] !== v) begin
        n = i;
        break;
      end
    end
  endtask : meas
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    foreach (offs[i]) begin
      rd(offs[i]);
      chk("reset reg", q, 32'h0);
    end
    chk("reset oe_n", {16'h0, chan_pins.oe_n}, 32'h0000FFFF);
    // Time bases have no host window, so this place must be refused
    rd(12'h020);
    chk("unmapped err", {31'h0, e}, 32'h1);
    chk("unmapped data", q, 32'h0);
    // Parameter words, top of map included
    foreach (ram_k[i]) wr(12'(256 + 4 * ram_k[i]), {8'h5A, 8'(ram_k[i]), 8'hA5, 8'(ram_k[i])});
    foreach (ram_k[i]) begin
      rd(12'(256 + 4 * ram_k[i]));
      chk("ram pair", q, {8'h5A, 8'(ram_k[i]), 8'hA5, 8'(ram_k[i])});
    end
    // Level first, then channel number, then rotation within a level
    wr(`TCP_OFF_PRIO, 32'h00000F40);
    order_q.delete();
    wr(`TCP_OFF_HSR, 32'h00000038);
    w(30);
    wr(`TCP_OFF_HSR, 32'h00000010);
    w(30);
    wr(`TCP_OFF_HSR, 32'h00000030);
    w(30);
    chk("grants", 32'(order_q.size()), 32'h6);
    foreach (exp_ord[i]) chk("order", {28'h0, order_q[i]}, {28'h0, exp_ord[i]});
    rd(`TCP_OFF_HSR);
    chk("flags cleared", q, 32'h0);
    // Host request on channel 0, then match-driven toggling
    wr(`TCP_OFF_PRIO, 32'h00000003);
    wr(`TCP_OFF_FUNC, 32'h00000001);
    wr(12'h100, 32'h00640000);
    wr(`TCP_OFF_HSR, 32'h00000001);
    rd(`TCP_OFF_FUNC);
    chk("read in service", q, 32'h1);
    w(20);
    chk("drive ch0", {31'h0, chan_pins.oe_n[0]}, 32'h0);
    chk("level ch0", {31'h0, chan_pins.level[0]}, 32'h1);
    meas(0, 200);
    meas(0, 200);
    rng("match period", n, 100, 112);
    wr(`TCP_OFF_CFG, 32'h00000002);
    meas(0, 600);
    meas(0, 600);
    rng("prescaled period", n, 398, 416);
    // Match on the external time base: frozen without edges
    wr(`TCP_OFF_CFG, 32'h00000040);
    wr(`TCP_OFF_TBSEL, 32'h00000001);
    meas(0, 600);
    meas(0, 300);
    rng("tb2 frozen", n, -1, -1);
    @(posedge pclk);
    ext_run <= 1'b1;
    meas(0, 1000);
    rng("tb2 period", n, 396, 420);
    @(posedge pclk);
    ext_run <= 1'b0;
    // Capture on channel 1 links to disabled channel 2
    wr(`TCP_OFF_FUNC, 32'h00000008);
    wr(`TCP_OFF_PRIO, 32'h00000008);
    @(posedge pclk);
    pin_in[1] <= 1'b1;
    w(30);
    rd(`TCP_OFF_HSR);
    chk("link flag", q & 32'h6, 32'h4);
    rd(12'h114);
    rng("capture age", 16'(q[31:16] - q[15:0]), 1, 12);
    // Emulation fetch overrides the do-nothing ROM function
    @(posedge pclk);
    emu_data <= 32'h00000003;
    wr(`TCP_OFF_CFG, 32'h00000080);
    wr(`TCP_OFF_FUNC, 32'h00000000);
    wr(`TCP_OFF_PRIO, 32'h0000C000);
    wr(`TCP_OFF_HSR, 32'h00000080);
    w(20);
    chk("emu drive", {31'h0, chan_pins.oe_n[7]}, 32'h0);
    chk("emu level", {31'h0, chan_pins.level[7]}, 32'h1);
    chk("emu addr", {23'h0, emu_addr}, 32'h00000007);
    // Host writes to the status word must not reach pin direction
    wr(`TCP_OFF_STAT, 32'hFFFFFFFF);
    rd(`TCP_OFF_STAT);
    chk("status", q, 32'h00070081);
    stop_test();
  end
  // Run is near 2000 cycles; this limit is well beyond it
  initial begin
    #2000000;
    err_total++;
    stop_test();
  end
endmodule : tb
